// [hdl/diss_defines.vh]
`ifndef DISS_DEFINES_VH
`define DISS_DEFINES_VH
`define DISS_NUM_STAGES 8
`define DISS_STAGE_MSB 7
`define DISS_FIFO_WIDTH 8
`define DISS_FIFO_DEPTH 32
`define DISS_FIFO_AW 5
`define DISS_SYNC_W 2
`define DISS_ZERO_BYTE 8'h00
`define DISS_BIT_CNT_W 3
`define DISS_BIT_CNT_ZERO 3'h0
`define DISS_BIT_CNT_LAST 3'h7
`define DISS_BIT_CNT_ONE 3'h1
`endif

// [hdl/diss_fifo.v]
`timescale 1ns/1ps
// ==========================================================================
// Synchronous FIFO with valid/ready on both sides.
// Read data comes out of a register.
module diss_fifo
#(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW = 5
)
(
  input wire clk_sys_i,
  input wire rst_i,
  input wire ce_i,
  input wire [WIDTH-1:0] wr_data_i,
  input wire wr_valid_i,
  output wire wr_ready_o,
  output reg [WIDTH-1:0] rd_data_o,
  output reg rd_valid_o,
  input wire rd_ready_i
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr_ff;
  reg [AW:0] rd_ptr_ff;
  wire empty;
  wire full;
  wire do_wr;
  wire do_rd;

  assign empty = (wr_ptr_ff == rd_ptr_ff);
  assign full = (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]) && (wr_ptr_ff[AW] != rd_ptr_ff[AW]);
  assign wr_ready_o = ~full;
  assign do_wr = wr_valid_i & ~full;
  // Refill the output register when it is empty or being drained.
  assign do_rd = ~empty & (~rd_valid_o | rd_ready_i);

  always @(posedge clk_sys_i)
  begin
    if (ce_i && do_wr)
    begin
      mem[wr_ptr_ff[AW-1:0]] <= wr_data_i;
    end
  end

  always @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      wr_ptr_ff <= {(AW+1){1'b0}};
      rd_ptr_ff <= {(AW+1){1'b0}};
      rd_valid_o <= 1'b0;
      rd_data_o <= {WIDTH{1'b0}};
    end
    else if (ce_i)
    begin
      if (do_wr)
      begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (do_rd)
      begin
        rd_data_o <= mem[rd_ptr_ff[AW-1:0]];
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
        rd_valid_o <= 1'b1;
      end
      else if (rd_ready_i)
      begin
        rd_valid_o <= 1'b0;
      end
    end
  end
endmodule

// [hdl/diss_top.v]
`timescale 1ns/1ps
// Summary of operation
// - Select falling edge loads eight inputs in parallel.
// - Shift clock rising edge shifts stages, chain in.
// - Select low drives output, enables shifting.
// - Select high floats output, ignores clock.
// - Output shows stage 8 when enabled.
// - Unconnected chain input reads as zero only with a pull-down at the pin.
// - After select falls, output shows input 8.
// - Mode 0 slave: sample and shift rising.
// - Two-device chain: sixteen bits per select.
`include "diss_defines.vh"
module diss_top
(
  input wire clk_sys_i,
  input wire rst_i,
  input wire ce_i,
  input wire [`DISS_STAGE_MSB:0] discrete_in_i,
  input wire select_n_i,
  input wire shift_clk_i,
  input wire chain_serial_in_i,
  output reg serial_out_o,
  output reg serial_out_oe_o,
  output wire [`DISS_FIFO_WIDTH-1:0] snap_data_o,
  output wire snap_valid_o,
  input wire snap_ready_i,
  output reg snap_drop_o
);
  // ==========================================================================
  // Input synchronisers.
  // Every discrete, select, shift clock and chain pin comes from outside this clock, so each passes two flops first.
  reg [`DISS_STAGE_MSB:0] din_meta_ff;
  reg [`DISS_STAGE_MSB:0] din_sync_ff;
  reg sel_meta_ff;
  reg sel_sync_ff;
  reg sel_prev_ff;
  reg sclk_meta_ff;
  reg sclk_sync_ff;
  reg sclk_prev_ff;
  reg chain_serial_in_meta_ff;
  reg chain_serial_in_sync_ff;

  always @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      din_meta_ff <= `DISS_ZERO_BYTE;
      din_sync_ff <= `DISS_ZERO_BYTE;
      sel_meta_ff <= 1'b1;
      sel_sync_ff <= 1'b1;
      sel_prev_ff <= 1'b1;
      sclk_meta_ff <= 1'b0;
      sclk_sync_ff <= 1'b0;
      sclk_prev_ff <= 1'b0;
      chain_serial_in_meta_ff <= 1'b0;
      chain_serial_in_sync_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      din_meta_ff <= discrete_in_i;
      din_sync_ff <= din_meta_ff;
      sel_meta_ff <= select_n_i;
      sel_sync_ff <= sel_meta_ff;
      sel_prev_ff <= sel_sync_ff;
      sclk_meta_ff <= shift_clk_i;
      sclk_sync_ff <= sclk_meta_ff;
      sclk_prev_ff <= sclk_sync_ff;
      // A floating chain input is expected to be pulled low at the pin, so
      // only a driven high shifts in a one.
      chain_serial_in_meta_ff <= chain_serial_in_i;
      chain_serial_in_sync_ff <= chain_serial_in_meta_ff;
    end
  end

  // ==========================================================================
  // Edge detection.
  wire sel_fall;
  wire sel_low;
  wire sclk_rise;

  assign sel_fall = sel_prev_ff & ~sel_sync_ff;
  assign sel_low = ~sel_sync_ff;
  // Only rising edges are looked for; falling edges pass unnoticed.
  assign sclk_rise = ~sclk_prev_ff & sclk_sync_ff;

  // ==========================================================================
  // Shift register.
  // Bit 0 is stage 1 and bit 7 is stage 8.
  reg [`DISS_STAGE_MSB:0] shift_stage_ff;
  reg [`DISS_STAGE_MSB:0] nxt_shift_stage;

  always @*
  begin
    nxt_shift_stage = shift_stage_ff;
    if (sel_fall)
    begin
      nxt_shift_stage = din_sync_ff;
    end
    else if (sel_low && sclk_rise)
    begin
      nxt_shift_stage = {shift_stage_ff[`DISS_STAGE_MSB-1:0], chain_serial_in_sync_ff};
    end
  end

  always @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      shift_stage_ff <= `DISS_ZERO_BYTE;
    end
    else if (ce_i)
    begin
      shift_stage_ff <= nxt_shift_stage;
    end
  end

  // ==========================================================================
  // Serial output.
  // The output flop follows the next stage value so it lines up with the
  // register in the same cycle, one flop after the decision.
  always @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      serial_out_o <= 1'b0;
      serial_out_oe_o <= 1'b0;
    end
    else if (ce_i)
    begin
      serial_out_o <= nxt_shift_stage[`DISS_STAGE_MSB];
      serial_out_oe_o <= sel_low;
    end
  end

  // ==========================================================================
  // Snapshot stream.
  // Each load also pushes the captured byte into a FIFO for local logic.
  // When the FIFO is full the snapshot is lost and a flag pulses, which is
  // preferred over stalling the serial link the master controls.
  wire snap_wr_ready;

  always @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      snap_drop_o <= 1'b0;
    end
    else if (ce_i)
    begin
      snap_drop_o <= sel_fall & ~snap_wr_ready;
    end
  end

  diss_fifo
  #(
    .WIDTH(`DISS_FIFO_WIDTH),
    .DEPTH(`DISS_FIFO_DEPTH),
    .AW(`DISS_FIFO_AW)
  )
  i_diss_fifo
  (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .wr_data_i(din_sync_ff),
    .wr_valid_i(sel_fall),
    .wr_ready_o(snap_wr_ready),
    .rd_data_o(snap_data_o),
    .rd_valid_o(snap_valid_o),
    .rd_ready_i(snap_ready_i)
  );
endmodule

// [tb/diss_master.sv]
`timescale 1ns/1ps
module diss_master(
  input wire clk_sys_i,
  input wire miso_i,
  output reg select_n_o = 1'b1,
  output reg sclk_o = 1'b0,
  output reg [15:0] rx_o
);
  integer k;
  task xfer;
    begin
      @(posedge clk_sys_i) select_n_o <= 1'b0;
      repeat (12) @(posedge clk_sys_i);
      for (k = 0; k < 16; k = k + 1)
      begin
        rx_o <= {rx_o[14:0], miso_i};
        sclk_o <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        sclk_o <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
      end
      select_n_o <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
    end
  endtask
endmodule

// [tb/diss_props.sv]
`timescale 1ns/1ps
module diss_props(
  input wire clk_sys_i,
  input wire rst_i,
  input wire [7:0] discrete_in_i,
  input wire select_n_i,
  input wire shift_clk_i,
  input wire serial_out_o,
  input wire serial_out_oe_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  property p_ld; $fell(select_n_i) |-> ##3 serial_out_o == discrete_in_i[7]; endproperty
  a_ld: assert property (p_ld) else $error("load");
  property p_on; $fell(select_n_i) |-> ##3 serial_out_oe_o; endproperty
  a_on: assert property (p_on) else $error("on");
  property p_off; $rose(select_n_i) |-> ##3 !serial_out_oe_o; endproperty
  a_off: assert property (p_off) else $error("off");
  property p_en; !select_n_i [*5] |-> serial_out_oe_o; endproperty
  a_en: assert property (p_en) else $error("en");
  property p_dis; select_n_i [*5] |-> !serial_out_oe_o; endproperty
  a_dis: assert property (p_dis) else $error("dis");
  property p_kp; select_n_i [*5] |=> $stable(serial_out_o); endproperty
  a_kp: assert property (p_kp) else $error("keep");
  property p_fl; $fell(shift_clk_i) |=> ##1 $stable(serial_out_o) [*3]; endproperty
  a_fl: assert property (p_fl) else $error("fall");
  property p_id; (!select_n_i && !shift_clk_i) [*5] |=> $stable(serial_out_o); endproperty
  a_id: assert property (p_id) else $error("idle");
endmodule
bind diss_top diss_props i_diss_props(.clk_sys_i, .rst_i, .discrete_in_i, .select_n_i,
  .shift_clk_i, .serial_out_o, .serial_out_oe_o);

// [tb/test_diss_top.sv]
`timescale 1ns/1ps
module test_diss_top;
  reg clk_sys_i = 1'b0, rst_i = 1'b1, snap_ready_i = 1'b0, chain_serial_in_i = 1'b0;
  reg [7:0] discrete_in_i = 8'h00;
  wire select_n_i, shift_clk_i, serial_out_o, serial_out_oe_o, snap_valid_o, snap_drop_o;
  wire [7:0] snap_data_o;
  reg [7:0] first_snap = 8'h00;
  integer n_drop = 0;
  wire [15:0] rx;
  reg [8:0] rows [0:1] = '{9'h0a5, 9'h15a};
  integer err_total = 0, total_checks = 0, i, n_out = 0;
  always #12.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) n_out <= n_out + (snap_valid_o & snap_ready_i);
  always @(posedge clk_sys_i) n_drop <= n_drop + snap_drop_o;
  always @(posedge clk_sys_i)
    if (snap_valid_o && snap_ready_i && n_out == 0) first_snap <= snap_data_o;
  diss_top i_diss_top(.clk_sys_i, .rst_i, .ce_i(1'b1), .discrete_in_i, .select_n_i,
    .shift_clk_i, .chain_serial_in_i, .serial_out_o, .serial_out_oe_o, .snap_data_o,
    .snap_valid_o, .snap_ready_i, .snap_drop_o);
  diss_master i_diss_master(.clk_sys_i, .miso_i(serial_out_o), .select_n_o(select_n_i),
    .sclk_o(shift_clk_i), .rx_o(rx));
  task check(input [15:0] got, input [15:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp)
      begin
        err_total = err_total + 1;
        $display("unexpected at %0t: bad word", $time);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  initial
  begin
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    // The consumer stalls over all 34 loads; 32 stored words plus the output
    // register hold 33, so exactly the last load is refused.
    for (i = 0; i < 34; i = i + 1)
    begin
      {chain_serial_in_i, discrete_in_i} <= rows[i % 2];
      i_diss_master.xfer;
      check(rx, {rows[i % 2][7:0], {8{rows[i % 2][8]}}});
    end
    snap_ready_i <= 1'b1;
    repeat (50) @(posedge clk_sys_i);
    check(n_out[15:0], 16'h0021);
    check(n_drop[15:0], 16'h0001);
    check({8'h00, first_snap}, 16'h00a5);
    // Mid-run reset: outputs must return to their idle values.
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    check({13'h0000, serial_out_o, serial_out_oe_o, snap_valid_o}, 16'h0000);
    {chain_serial_in_i, discrete_in_i} <= rows[0];
    i_diss_master.xfer;
    check(rx, {rows[0][7:0], 8'h00});
    report_and_stop;
  end
  initial
  begin
    #500000;
    err_total = err_total + 1;
    report_and_stop;
  end
endmodule
